// ---- verilog/gxc_pkg.sv ----
// Shared constants and types of the graphics extension command unit.
package gxc_pkg;

   // ****************************************
   // Command opcodes and parameter layout
   // ****************************************
   localparam logic [7:0] GXC_OP_WRITE_GATE = 8'h5a;
   localparam logic [7:0] GXC_OP_RESET_DEFAULT = 8'h00;
   localparam int GXC_CTL_ADDR_WIDEN = 7;
   localparam int GXC_CTL_SYNC_TM = 6;
   localparam int GXC_CTL_STROBE_EN = 5;
   localparam int GXC_CTL_MODE_HI = 4;
   localparam int GXC_CTL_MODE_LO = 3;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [15:0] GXC_GATE_RESET = 16'hffff;
   localparam logic GXC_WIDEN_RESET = 1'b0;
   localparam logic GXC_TM_RESET = 1'b0;
   localparam logic [2:0] GXC_STROBE_RESET = 3'h0;

   // ****************************************
   // Address widths and sync stages
   // ****************************************
   localparam int GXC_AW_MAX = 20;
   localparam int GXC_AW_CHAR_EXT = 15;
   localparam int GXC_AW_MIXED_EXT = 18;
   localparam int GXC_AW_GRAPH_EXT = 20;
   localparam int GXC_AW_WIDEN_BITS = 2;
   localparam int GXC_SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      GXC_DISP_CHAR,
      GXC_DISP_MIXED,
      GXC_DISP_GRAPH
   } gxc_disp_t;

   typedef enum logic [2:0] {
      GXC_STB_LEGACY0,
      GXC_STB_LEGACY1,
      GXC_STB_XFER0,
      GXC_STB_XFER1,
      GXC_STB_XFER2,
      GXC_STB_INHIBIT
   } gxc_strobe_t;

   typedef enum logic [1:0] {
      GXC_CAP_IDLE,
      GXC_CAP_LOW,
      GXC_CAP_HIGH,
      GXC_CAP_CTRL
   } gxc_cap_t;

endpackage : gxc_pkg

// ---- verilog/gxc_gate_if.sv ----
// Interface carrying one drawn word and its masks to the bit gate.
`timescale 1ns/100ps
`default_nettype none
interface gxc_gate_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] old_word;
   logic [WIDTH-1:0] new_word;
   logic [WIDTH-1:0] conv_mask;
   logic [WIDTH-1:0] gate_mask;
   logic [WIDTH-1:0] result;

   modport ctrl (output old_word, output new_word, output conv_mask, output gate_mask,
      input result);
   modport gate (input old_word, input new_word, input conv_mask, input gate_mask,
      output result);
endinterface : gxc_gate_if
`default_nettype wire

// ---- verilog/gxc_bit_gate.sv ----
// Bit-wise merge of a drawn word into the old memory word under both masks.
`timescale 1ns/100ps
`default_nettype none
module gxc_bit_gate #(
   parameter int WIDTH = 16
) (
   gxc_gate_if.gate port_if
);
   import gxc_pkg::*;

   initial begin
      if (WIDTH < 1) begin
         $error("gxc_bit_gate: WIDTH must be at least 1");
      end
   end

   // RULE_03 RULE_18 - both masks gate
   always_comb begin
      port_if.result = (port_if.new_word & port_if.conv_mask & port_if.gate_mask)
         | (port_if.old_word & ~(port_if.conv_mask & port_if.gate_mask));
   end
endmodule : gxc_bit_gate
`default_nettype wire

// ---- verilog/gxc_command_unit.sv ----
// Command decode extension: write gate, address widening, sync timing and strobe mode.
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE_01 - Gate command 0x5a then low, high and control bytes in fixed layout.
// RULE_02 - A 16-bit gate mask exists beside the conventional mask.
// RULE_03 - Gate bit 0 keeps the memory bit unchanged during drawing.
// RULE_04 - Gate bit 1 lets drawing change the bit; reset restores all ones.
// RULE_05 - Reset command drops every gate command setting back to legacy behaviour.
// RULE_06 - Widen bit 0 means legacy addressing without extension.
// RULE_07 - Widen bit 1 adds two address bits, four times the space.
// RULE_08 - While widened, DMA pins carry upper address bits and DMA is off.
// RULE_09 - Widened address is 15, 18 or 20 bits by display mode.
// RULE_10 - Widening also stretches light pen, execute and display start pointers.
// RULE_11 - Every legacy command passes on under its own opcode.
// RULE_12 - Sync timing bit matters only in external sync slave mode.
// RULE_13 - Timing bit 0 clears counters at front porch start as before.
// RULE_14 - Timing bit 1 clears horizontal counter at sync period rising edge.
// RULE_15 - Timing bit 1 in interlace forces the field counter to field one.
// RULE_16 - External source sends only first-field vertical sync in interlace.
// RULE_17 - Strobe bits decode to legacy 0, legacy 1, transfer 0-2, else inhibited.
// RULE_18 - Drawing writes change a bit only when both masks allow.
module gxc_command_unit #(
   parameter int GATE_WIDTH = 16,
   parameter logic [7:0] RESET_OPCODE = gxc_pkg::GXC_OP_RESET_DEFAULT
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic host_wr_in,
   input wire logic host_is_cmd_in,
   input wire logic [7:0] host_byte_in,
   input wire logic draw_valid_in,
   input wire logic [GATE_WIDTH-1:0] draw_old_in,
   input wire logic [GATE_WIDTH-1:0] draw_new_in,
   input wire logic [GATE_WIDTH-1:0] conv_mask_in,
   input wire gxc_pkg::gxc_disp_t display_mode_in,
   input wire logic [gxc_pkg::GXC_AW_MAX-1:0] mem_addr_in,
   input wire logic dma_req_in,
   input wire logic dma_ack_in,
   input wire logic [gxc_pkg::GXC_AW_MAX-1:0] light_pen_position_in,
   input wire logic [gxc_pkg::GXC_AW_MAX-1:0] execute_pointer_in,
   input wire logic [gxc_pkg::GXC_AW_MAX-1:0] display_start_pointer_in,
   input wire logic slave_mode_in,
   input wire logic interlace_in,
   input wire logic external_sync_input_in,
   input wire logic horizontal_sync_period_in,
   input wire logic front_porch_start_in,
   output logic fwd_valid_out,
   output logic fwd_is_cmd_out,
   output logic [7:0] fwd_byte_out,
   output logic draw_done_out,
   output logic [GATE_WIDTH-1:0] draw_word_out,
   output logic [gxc_pkg::GXC_AW_MAX-1:0] vmem_addr_out,
   output logic drq_pin_out,
   output logic dack_pin_out,
   output logic dma_enable_out,
   output logic [gxc_pkg::GXC_AW_MAX-1:0] light_pen_position_out,
   output logic [gxc_pkg::GXC_AW_MAX-1:0] execute_pointer_out,
   output logic [gxc_pkg::GXC_AW_MAX-1:0] display_start_pointer_out,
   output logic [GATE_WIDTH-1:0] gate_mask_out,
   output logic address_widen_enable_out,
   output logic external_sync_timing_select_out,
   output gxc_pkg::gxc_strobe_t strobe_mode_out,
   output logic hcount_clear_out,
   output logic field_force_first_out
);
   import gxc_pkg::*;

   initial begin
      if (GATE_WIDTH != 16) begin
         $error("gxc_command_unit: the gate command carries exactly 16 mask bits");
      end
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      gxc_cap_t cap;
      logic [7:0] low_byte;
      logic [GATE_WIDTH-1:0] gate;
      logic widen;
      logic sync_tm;
      logic [2:0] strobe_bits;
      gxc_strobe_t strobe;
      logic [GXC_SYNC_STAGES-1:0] ext_sync;
      logic ext_lvl;
      logic hs_prev;
      logic pend;
      logic pend_tm;
      logic hclr;
      logic field_first;
      logic fwd_v;
      logic fwd_cmd;
      logic [7:0] fwd_byte;
      logic draw_done;
      logic [GATE_WIDTH-1:0] draw_word;
      logic [GXC_AW_MAX-1:0] vaddr;
      logic drq;
      logic dack;
      logic dma_en;
      logic [GXC_AW_MAX-1:0] light_pen_read_cmd;
      logic [GXC_AW_MAX-1:0] exec;
      logic [GXC_AW_MAX-1:0] start;
   } gxc_state_t;

   gxc_state_t st_ff;
   gxc_state_t nxt_st;

   gxc_gate_if #(.WIDTH(GATE_WIDTH)) gate_bus ();

   gxc_bit_gate #(.WIDTH(GATE_WIDTH)) u_gate (
      .port_if(gate_bus.gate)
   );

   assign gate_bus.old_word = draw_old_in;
   assign gate_bus.new_word = draw_new_in;
   assign gate_bus.conv_mask = conv_mask_in;
   assign gate_bus.gate_mask = st_ff.gate;

   // ****************************************
   // Address width helpers
   // ****************************************
   function automatic int addr_width(input gxc_disp_t mode, input logic widen);
      int w;
      case (mode)
         GXC_DISP_CHAR: w = GXC_AW_CHAR_EXT;
         GXC_DISP_MIXED: w = GXC_AW_MIXED_EXT;
         default: w = GXC_AW_GRAPH_EXT;
      endcase
      // RULE_06 RULE_07 - two extra bits
      if (!widen) begin
         w = w - GXC_AW_WIDEN_BITS;
      end
      return w;
   endfunction : addr_width

   function automatic logic [GXC_AW_MAX-1:0] clip(input logic [GXC_AW_MAX-1:0] a,
      input int w);
      logic [GXC_AW_MAX-1:0] m;
      m = '0;
      for (int i = 0; i < GXC_AW_MAX; i++) begin
         m[i] = (i < w);
      end
      return a & m;
   endfunction : clip

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      int w;
      logic reset_evt;
      logic ext_rise;
      logic hs_rise;
      logic sync_evt;
      w = 0;
      reset_evt = 1'b0;
      ext_rise = 1'b0;
      hs_rise = 1'b0;
      sync_evt = 1'b0;
      nxt_st = st_ff;
      nxt_st.hclr = 1'b0;
      nxt_st.field_first = 1'b0;
      nxt_st.fwd_v = 1'b0;
      nxt_st.draw_done = 1'b0;

      // The first stage feeds only the second; the filter reads stages two and three.
      nxt_st.ext_sync = {st_ff.ext_sync[GXC_SYNC_STAGES-2:0], external_sync_input_in};
      if (st_ff.ext_sync[1] == st_ff.ext_sync[2]) begin
         nxt_st.ext_lvl = st_ff.ext_sync[2];
      end
      ext_rise = nxt_st.ext_lvl & ~st_ff.ext_lvl;
      nxt_st.hs_prev = horizontal_sync_period_in;
      hs_rise = horizontal_sync_period_in & ~st_ff.hs_prev;

      if (host_wr_in) begin
         if (host_is_cmd_in) begin
            nxt_st.cap = GXC_CAP_IDLE;
            // RULE_01 - gate command opcode
            if (host_byte_in == GXC_OP_WRITE_GATE) begin
               nxt_st.cap = GXC_CAP_LOW;
            end else begin
               // RULE_11 - legacy pass-through
               nxt_st.fwd_v = 1'b1;
               nxt_st.fwd_cmd = 1'b1;
               nxt_st.fwd_byte = host_byte_in;
               if (host_byte_in == RESET_OPCODE) begin
                  reset_evt = 1'b1;
                  // RULE_04 RULE_05 - back to legacy
                  nxt_st.gate = GXC_GATE_RESET;
                  nxt_st.widen = GXC_WIDEN_RESET;
                  nxt_st.sync_tm = GXC_TM_RESET;
                  nxt_st.strobe_bits = GXC_STROBE_RESET;
               end
            end
         end else begin
            case (st_ff.cap)
               GXC_CAP_LOW: begin
                  nxt_st.low_byte = host_byte_in;
                  nxt_st.cap = GXC_CAP_HIGH;
               end
               GXC_CAP_HIGH: begin
                  // RULE_02 - load 16-bit gate
                  nxt_st.gate = {host_byte_in, st_ff.low_byte};
                  nxt_st.cap = GXC_CAP_CTRL;
               end
               GXC_CAP_CTRL: begin
                  // RULE_01 - control byte fields
                  nxt_st.widen = host_byte_in[GXC_CTL_ADDR_WIDEN];
                  nxt_st.sync_tm = host_byte_in[GXC_CTL_SYNC_TM];
                  nxt_st.strobe_bits = {host_byte_in[GXC_CTL_STROBE_EN],
                     host_byte_in[GXC_CTL_MODE_HI], host_byte_in[GXC_CTL_MODE_LO]};
                  nxt_st.cap = GXC_CAP_IDLE;
               end
               default: begin
                  // RULE_11 - legacy parameters
                  nxt_st.fwd_v = 1'b1;
                  nxt_st.fwd_cmd = 1'b0;
                  nxt_st.fwd_byte = host_byte_in;
               end
            endcase
         end
      end

      // RULE_17 - strobe decode
      case (nxt_st.strobe_bits)
         3'h0: nxt_st.strobe = GXC_STB_LEGACY0;
         3'h1: nxt_st.strobe = GXC_STB_LEGACY1;
         3'h4: nxt_st.strobe = GXC_STB_XFER0;
         3'h6: nxt_st.strobe = GXC_STB_XFER1;
         3'h7: nxt_st.strobe = GXC_STB_XFER2;
         default: nxt_st.strobe = GXC_STB_INHIBIT;
      endcase

      // RULE_13 RULE_14 - pending clear resolves
      if (st_ff.pend) begin
         if ((st_ff.pend_tm && hs_rise) || (!st_ff.pend_tm && front_porch_start_in)) begin
            nxt_st.hclr = 1'b1;
            nxt_st.pend = 1'b0;
         end
      end
      // RULE_12 RULE_16 - slave-only events
      sync_evt = slave_mode_in & (ext_rise | reset_evt);
      // A new event outranks the resolve above, so it is never lost.
      if (sync_evt) begin
         nxt_st.pend = 1'b1;
         nxt_st.pend_tm = st_ff.sync_tm;
         // RULE_15 - force first field
         nxt_st.field_first = st_ff.sync_tm & interlace_in;
      end

      // RULE_03 RULE_18 - gated drawing write
      if (draw_valid_in) begin
         nxt_st.draw_word = gate_bus.result;
         nxt_st.draw_done = 1'b1;
      end

      // The width follows the widen bit being registered, so that pins, address and the
      // DMA enable switch over on the same edge as the widen flag itself.
      w = addr_width(display_mode_in, nxt_st.widen);
      // RULE_09 - width by mode
      nxt_st.vaddr = clip(mem_addr_in, w);
      // RULE_08 - pins carry upper bits
      if (nxt_st.widen) begin
         nxt_st.drq = mem_addr_in[w-2];
         nxt_st.dack = mem_addr_in[w-1];
      end else begin
         nxt_st.drq = dma_req_in;
         nxt_st.dack = dma_ack_in;
      end
      nxt_st.dma_en = ~nxt_st.widen;
      // RULE_10 - widened pointers
      nxt_st.light_pen_read_cmd = clip(light_pen_position_in, w);
      nxt_st.exec = clip(execute_pointer_in, w);
      nxt_st.start = clip(display_start_pointer_in, w);
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_ff <= '0;
         st_ff.cap <= GXC_CAP_IDLE;
         st_ff.gate <= GXC_GATE_RESET;
         st_ff.widen <= GXC_WIDEN_RESET;
         st_ff.sync_tm <= GXC_TM_RESET;
         st_ff.strobe_bits <= GXC_STROBE_RESET;
         st_ff.strobe <= GXC_STB_LEGACY0;
         st_ff.dma_en <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign fwd_valid_out = st_ff.fwd_v;
   assign fwd_is_cmd_out = st_ff.fwd_cmd;
   assign fwd_byte_out = st_ff.fwd_byte;
   assign draw_done_out = st_ff.draw_done;
   assign draw_word_out = st_ff.draw_word;
   assign vmem_addr_out = st_ff.vaddr;
   assign drq_pin_out = st_ff.drq;
   assign dack_pin_out = st_ff.dack;
   assign dma_enable_out = st_ff.dma_en;
   assign light_pen_position_out = st_ff.light_pen_read_cmd;
   assign execute_pointer_out = st_ff.exec;
   assign display_start_pointer_out = st_ff.start;
   assign gate_mask_out = st_ff.gate;
   assign address_widen_enable_out = st_ff.widen;
   assign external_sync_timing_select_out = st_ff.sync_tm;
   assign strobe_mode_out = st_ff.strobe;
   assign hcount_clear_out = st_ff.hclr;
   assign field_force_first_out = st_ff.field_first;
endmodule : gxc_command_unit
`default_nettype wire

// ---- dv/gxc_command_unit_checker.sv ----
// Port-level assertions of the graphics extension command unit.
`timescale 1ns/100ps
`default_nettype none
module gxc_command_unit_checker #(
   parameter int GATE_WIDTH = 16,
   parameter logic [7:0] RESET_OPCODE = 8'h00
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic host_wr_in,
   input wire logic host_is_cmd_in,
   input wire logic [7:0] host_byte_in,
   input wire logic draw_valid_in,
   input wire logic [GATE_WIDTH-1:0] draw_old_in,
   input wire logic [GATE_WIDTH-1:0] draw_new_in,
   input wire logic [GATE_WIDTH-1:0] conv_mask_in,
   input wire logic slave_mode_in,
   input wire logic interlace_in,
   input wire logic horizontal_sync_period_in,
   input wire logic front_porch_start_in,
   input wire logic fwd_valid_out,
   input wire logic [7:0] fwd_byte_out,
   input wire logic draw_done_out,
   input wire logic [GATE_WIDTH-1:0] draw_word_out,
   input wire logic [gxc_pkg::GXC_AW_MAX-1:0] vmem_addr_out,
   input wire logic dma_enable_out,
   input wire logic [GATE_WIDTH-1:0] gate_mask_out,
   input wire logic address_widen_enable_out,
   input wire logic external_sync_timing_select_out,
   input wire gxc_pkg::gxc_strobe_t strobe_mode_out,
   input wire logic hcount_clear_out,
   input wire logic field_force_first_out
);
   import gxc_pkg::*;
   localparam gxc_strobe_t STB [8] = '{GXC_STB_LEGACY0, GXC_STB_LEGACY1, GXC_STB_INHIBIT,
      GXC_STB_INHIBIT, GXC_STB_XFER0, GXC_STB_INHIBIT, GXC_STB_XFER1, GXC_STB_XFER2};
   logic [7:0] last_byte_ff;
   always_ff @(posedge mclk_in) begin
      last_byte_ff <= host_byte_in;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_gate_open;
      host_wr_in && host_is_cmd_in && host_byte_in == GXC_OP_WRITE_GATE;
   endsequence
   sequence s_param;
      host_wr_in && !host_is_cmd_in;
   endsequence
   a_gate_load:
      assert property (s_gate_open ##1 s_param ##1 s_param |=>
         gate_mask_out == {last_byte_ff, $past(host_byte_in, 2)}) else $error("gate mask load");
   a_ctrl_fields:
      assert property (s_gate_open ##1 s_param[*3] |=> strobe_mode_out == STB[last_byte_ff[5:3]]
         && address_widen_enable_out == last_byte_ff[7]
         && external_sync_timing_select_out == last_byte_ff[6]) else $error("control fields");
   a_reset_cmd:
      assert property (host_wr_in && host_is_cmd_in && host_byte_in == RESET_OPCODE |=>
         gate_mask_out == GXC_GATE_RESET && !address_widen_enable_out
         && !external_sync_timing_select_out && strobe_mode_out == GXC_STB_LEGACY0)
         else $error("reset command defaults");
   a_fwd_legacy:
      assert property (host_wr_in && host_is_cmd_in && host_byte_in != GXC_OP_WRITE_GATE |=>
         fwd_valid_out && fwd_byte_out == $past(host_byte_in)) else $error("legacy forward");
   a_draw_merge:
      assert property (draw_valid_in |=> draw_done_out && draw_word_out ==
         (($past(draw_new_in) & $past(conv_mask_in) & $past(gate_mask_out))
         | ($past(draw_old_in) & ~($past(conv_mask_in) & $past(gate_mask_out)))))
         else $error("draw merge");
   a_dma_off:
      assert property (dma_enable_out != address_widen_enable_out) else $error("dma enable");
   a_narrow_addr:
      assert property (!address_widen_enable_out && !$past(address_widen_enable_out) |->
         vmem_addr_out[19:18] == 2'h0) else $error("narrow address");
   a_hclear_cause:
      assert property (hcount_clear_out |-> ($past(front_porch_start_in)
         && !$past(external_sync_timing_select_out)) || ($past(external_sync_timing_select_out)
         && $past(horizontal_sync_period_in) && !$past(horizontal_sync_period_in, 2)))
         else $error("horizontal clear cause");
   a_field_force:
      assert property (field_force_first_out |-> $past(interlace_in) && $past(slave_mode_in)
         && $past(external_sync_timing_select_out)) else $error("field force cause");
endmodule : gxc_command_unit_checker
bind gxc_command_unit gxc_command_unit_checker #(.GATE_WIDTH(GATE_WIDTH),
   .RESET_OPCODE(RESET_OPCODE)) gxc_command_unit_checker_i (.*);
`default_nettype wire

// ---- dv/gxc_host_model.sv ----
// Behavioural host that issues command and parameter bytes.
`timescale 1ns/100ps
`default_nettype none
module gxc_host_model (
   input wire logic mclk_in,
   output var logic wr_out,
   output var logic is_cmd_out,
   output var logic [7:0] byte_out
);
   initial begin
      wr_out = 1'b0;
      is_cmd_out = 1'b0;
      byte_out = 8'h00;
   end
   task automatic put(input logic cmd, input logic [7:0] b);
      wr_out = 1'b1;
      is_cmd_out = cmd;
      byte_out = b;
      @(posedge mclk_in);
      #1;
   endtask : put
   // A released bus shows the inverse so a stale byte never passes for a fresh one.
   task automatic idle();
      wr_out = 1'b0;
      byte_out = ~byte_out;
   endtask : idle
   task automatic gate_seq(input logic [15:0] mask, input logic [7:0] ctrl);
      put(1'b1, 8'h5a);
      put(1'b0, mask[7:0]);
      put(1'b0, mask[15:8]);
      put(1'b0, {ctrl[7:3], 3'h0});
      idle();
      // One idle edge, so a following sequence never lifts the strobe in the same step.
      @(posedge mclk_in);
      #1;
   endtask : gate_seq
endmodule : gxc_host_model
`default_nettype wire

// ---- dv/tb_gxc_command_unit.sv ----
// Self-checking bench of the graphics extension command unit.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_gxc_command_unit;
   import gxc_pkg::*;
   typedef struct packed {logic [15:0] g, o, n, c, e;} gxc_row_t;
   gxc_row_t rows [4] = '{'{16'hffff, 16'h0000, 16'hffff, 16'hffff, 16'hffff},
      '{16'h0000, 16'ha5a5, 16'h5a5a, 16'hffff, 16'ha5a5},
      '{16'h00ff, 16'h0000, 16'hffff, 16'h0f0f, 16'h000f},
      '{16'hff00, 16'hffff, 16'h0000, 16'hffff, 16'h00ff}};
   gxc_strobe_t stb [8] = '{GXC_STB_LEGACY0, GXC_STB_LEGACY1, GXC_STB_INHIBIT,
      GXC_STB_INHIBIT, GXC_STB_XFER0, GXC_STB_INHIBIT, GXC_STB_XFER1, GXC_STB_XFER2};
   int checked = 0, mismatches = 0;
   logic mclk_in = 1'b0, resetn_in = 1'b0, host_wr_in, host_is_cmd_in, draw_valid_in = 1'b0;
   logic dma_req_in = 1'b1, dma_ack_in = 1'b1, slave_mode_in = 1'b0, interlace_in = 1'b0;
   logic external_sync_input_in = 1'b0, horizontal_sync_period_in = 1'b0;
   logic front_porch_start_in = 1'b0;
   logic [7:0] host_byte_in, fwd_byte_out;
   logic [15:0] draw_old_in = '0, draw_new_in = '0, conv_mask_in = '0, draw_word_out;
   logic [15:0] gate_mask_out;
   gxc_disp_t display_mode_in = GXC_DISP_GRAPH;
   logic [19:0] mem_addr_in = '0, light_pen_position_in = '0, execute_pointer_in = '0;
   logic [19:0] display_start_pointer_in = '0, vmem_addr_out, light_pen_position_out;
   logic [19:0] execute_pointer_out, display_start_pointer_out;
   logic fwd_valid_out, fwd_is_cmd_out, draw_done_out, drq_pin_out, dack_pin_out;
   logic dma_enable_out, address_widen_enable_out, external_sync_timing_select_out;
   logic hcount_clear_out, field_force_first_out;
   gxc_strobe_t strobe_mode_out;
   gxc_command_unit gxc_command_unit_i (.*);
   gxc_host_model gxc_host_model_i (.mclk_in, .wr_out(host_wr_in), .is_cmd_out(host_is_cmd_in),
      .byte_out(host_byte_in));
   initial begin
      forever #4 mclk_in = ~mclk_in;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : tick
   task automatic wait_hi(ref logic s, input string nm);
      for (int k = 0; k < 12 && s !== 1'b1; k++) tick(1);
      `CHK(nm, 1'b1, s)
   endtask : wait_hi
   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (5000) @(posedge mclk_in);
      mismatches++;
      complete_run();
   end
   initial begin
      tick(6);
      resetn_in = 1'b1;
      `CHK("gate", 16'hffff, gate_mask_out)
      `CHK("dma", 1'b1, dma_enable_out)
      `CHK("strobe", GXC_STB_LEGACY0, strobe_mode_out)
      $display("test reset done");
      foreach (rows[i]) begin
         gxc_host_model_i.gate_seq(rows[i].g, 8'h00);
         `CHK("gate", rows[i].g, gate_mask_out)
         {draw_valid_in, draw_old_in} = {1'b1, rows[i].o};
         {draw_new_in, conv_mask_in} = {rows[i].n, rows[i].c};
         tick(1);
         draw_valid_in = 1'b0;
         `CHK("done", 1'b1, draw_done_out)
         `CHK("word", rows[i].e, draw_word_out)
      end
      $display("test draw done");
      for (int c = 0; c < 8; c++) begin
         gxc_host_model_i.gate_seq(16'hffff, {2'h0, 3'(c), 3'h0});
         `CHK("strobe", stb[c], strobe_mode_out)
      end
      $display("test strobe done");
      gxc_host_model_i.gate_seq(16'hffff, 8'h80);
      mem_addr_in = 20'h7ffff;
      light_pen_position_in = 20'hfffff;
      execute_pointer_in = 20'hfffff;
      display_start_pointer_in = 20'hfffff;
      tick(2);
      `CHK("addr", 20'h7ffff, vmem_addr_out)
      `CHK("pins", 3'h4, {drq_pin_out, dack_pin_out, dma_enable_out})
      `CHK("light_pen_read_cmd", 20'hfffff, light_pen_position_out)
      `CHK("exec", 20'hfffff, execute_pointer_out)
      `CHK("start", 20'hfffff, display_start_pointer_out)
      display_mode_in = GXC_DISP_CHAR;
      tick(2);
      `CHK("addr", 20'h07fff, vmem_addr_out)
      `CHK("pins", 3'h6, {drq_pin_out, dack_pin_out, dma_enable_out})
      `CHK("exec", 20'h07fff, execute_pointer_out)
      `CHK("start", 20'h07fff, display_start_pointer_out)
      display_mode_in = GXC_DISP_GRAPH;
      gxc_host_model_i.put(1'b1, 8'h00);
      gxc_host_model_i.idle();
      `CHK("reset", 3'h5, {fwd_valid_out, address_widen_enable_out, fwd_byte_out == 8'h00})
      tick(2);
      `CHK("addr", 20'h3ffff, vmem_addr_out)
      `CHK("pins", 3'h7, {drq_pin_out, dack_pin_out, dma_enable_out})
      $display("test widen done");
      gxc_host_model_i.put(1'b1, 8'h5a);
      gxc_host_model_i.put(1'b0, 8'h12);
      `CHK("param fwd", 1'b0, fwd_valid_out)
      gxc_host_model_i.put(1'b1, 8'h47);
      gxc_host_model_i.idle();
      `CHK("fwd", 10'h347, {fwd_valid_out, fwd_is_cmd_out, fwd_byte_out})
      `CHK("gate", 16'hffff, gate_mask_out)
      $display("test abort done");
      tick(1);
      gxc_host_model_i.gate_seq(16'hffff, 8'h40);
      {slave_mode_in, interlace_in} = 2'h3;
      external_sync_input_in = 1'b1;
      wait_hi(field_force_first_out, "field");
      tick(3);
      `CHK("early clear", 1'b0, hcount_clear_out)
      horizontal_sync_period_in = 1'b1;
      wait_hi(hcount_clear_out, "hclear");
      {external_sync_input_in, horizontal_sync_period_in} = 2'h0;
      gxc_host_model_i.gate_seq(16'hffff, 8'h00);
      tick(6);
      external_sync_input_in = 1'b1;
      tick(6);
      front_porch_start_in = 1'b1;
      tick(1);
      front_porch_start_in = 1'b0;
      wait_hi(hcount_clear_out, "hclear");
      $display("test sync done");
      gxc_host_model_i.gate_seq(16'h1234, 8'hc0);
      `CHK("gate", 16'h1234, gate_mask_out)
      resetn_in = 1'b0;
      tick(1);
      resetn_in = 1'b1;
      `CHK("gate", 16'hffff, gate_mask_out)
      `CHK("widen", 2'h1, {address_widen_enable_out, dma_enable_out})
      `CHK("tm", 1'b0, external_sync_timing_select_out)
      $display("test async reset done");
      complete_run();
   end
endmodule : tb_gxc_command_unit
`default_nettype wire
